// [logic/dot_matrix_pkg.sv]
package dot_matrix_pkg;
    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int unsigned CHAR_COUNT = 4;
    localparam int unsigned COL_COUNT = 5;
    localparam int unsigned ROW_COUNT = 7;
    localparam int unsigned SHIFT_BITS = CHAR_COUNT * ROW_COUNT;
    localparam int unsigned COL_W = 3;
    localparam logic [SHIFT_BITS-1:0] SHIFT_RESET = 28'h0000000;
    localparam logic [COL_COUNT-1:0] STROBE_OFF = 5'h00;

    // ----------------------------------------
    // Timing at 200 MHz ref_clk
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned CLK_HALF_NS = 100;
    localparam int unsigned CLK_HALF_CYC = (CLK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned STROBE_US = 20;
    localparam int unsigned STROBE_CYC = (STROBE_US * 1000000) / CLK_PERIOD_PS;
    localparam int unsigned CNT_W = 13;

    // ----------------------------------------
    // Buffer
    // ----------------------------------------
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned FIFO_WIDTH = SHIFT_BITS;
endpackage

// [logic/dot_matrix_link.sv]
`timescale 1ns/100ps
interface dot_matrix_link;
    logic shift_clock;
    logic serial_data_in;
    logic serial_data_out;
    logic [dot_matrix_pkg::COL_COUNT-1:0] column_strobe_input;
    logic blanking_input;

    modport display (
        input shift_clock,
        input serial_data_in,
        output serial_data_out,
        input column_strobe_input,
        input blanking_input
    );
    modport controller (
        output shift_clock,
        output serial_data_in,
        input serial_data_out,
        output column_strobe_input,
        output blanking_input
    );
endinterface

// [logic/column_fifo.sv]
`timescale 1ns/100ps
module column_fifo #(
    parameter int unsigned WIDTH = dot_matrix_pkg::FIFO_WIDTH,
    parameter int unsigned DEPTH = dot_matrix_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk, // Clock
    input wire logic reset_n, // Sync reset
    input wire logic in_valid, // Write request
    output logic in_ready, // Not full
    input wire logic [WIDTH-1:0] in_data, // Write word
    output logic out_valid, // Not empty
    input wire logic out_ready, // Read accept
    output logic [WIDTH-1:0] out_data // Head word
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = (AW+1)'(cnt_q + push - pop);
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    assign in_ready = cnt_q != (AW+1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_q];
endmodule // column_fifo

// [logic/dot_matrix_display.sv]
`timescale 1ns/100ps
module dot_matrix_display (
    input wire logic ref_clk, // Clock
    input wire logic reset_n, // Sync reset
    dot_matrix_link.display link, // Controller side
    output logic [dot_matrix_pkg::SHIFT_BITS-1:0] row_drive, // Row drivers on
    output logic [dot_matrix_pkg::COL_COUNT-1:0] column_lit // Lit columns
);
    logic [2:0] clk_sync_q, clk_sync_d;
    logic [1:0] din_sync_q, din_sync_d;
    logic [1:0] blank_sync_q, blank_sync_d;
    logic [dot_matrix_pkg::COL_COUNT-1:0] col_s1_q, col_s1_d, col_s2_q, col_s2_d;
    logic [dot_matrix_pkg::SHIFT_BITS-1:0] shift_q, shift_d;
    logic [dot_matrix_pkg::SHIFT_BITS-1:0] row_q, row_d;
    logic [dot_matrix_pkg::COL_COUNT-1:0] lit_q, lit_d;
    logic fall;

    // ----------------------------------------
    // Synchronisers and shift register
    // ----------------------------------------
    always_comb begin
        clk_sync_d = {clk_sync_q[1:0], link.shift_clock};
        din_sync_d = {din_sync_q[0], link.serial_data_in};
        blank_sync_d = {blank_sync_q[0], link.blanking_input};
        col_s1_d = link.column_strobe_input;
        col_s2_d = col_s1_q;
        fall = clk_sync_q[2] && !clk_sync_q[1];
        shift_d = shift_q;
        if (fall) begin
            shift_d = {shift_q[dot_matrix_pkg::SHIFT_BITS-2:0], din_sync_q[1]}; // [RULE_02] [RULE_03] [RULE_05]
        end
        row_d = shift_q; // [RULE_04]
        lit_d = blank_sync_q[1] ? col_s2_q : dot_matrix_pkg::STROBE_OFF; // [RULE_10] [RULE_01]
        if (!blank_sync_q[1]) begin
            row_d = dot_matrix_pkg::SHIFT_RESET; // [RULE_10]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            clk_sync_q <= 3'h0;
            din_sync_q <= 2'h0;
            blank_sync_q <= 2'h0;
            col_s1_q <= dot_matrix_pkg::STROBE_OFF;
            col_s2_q <= dot_matrix_pkg::STROBE_OFF;
            shift_q <= dot_matrix_pkg::SHIFT_RESET;
            row_q <= dot_matrix_pkg::SHIFT_RESET;
            lit_q <= dot_matrix_pkg::STROBE_OFF;
        end else begin
            clk_sync_q <= clk_sync_d;
            din_sync_q <= din_sync_d;
            blank_sync_q <= blank_sync_d;
            col_s1_q <= col_s1_d;
            col_s2_q <= col_s2_d;
            shift_q <= shift_d;
            row_q <= row_d;
            lit_q <= lit_d;
        end
    end

    assign link.serial_data_out = shift_q[dot_matrix_pkg::SHIFT_BITS-1]; // [RULE_03]
    assign row_drive = row_q;
    assign column_lit = lit_q;
endmodule // dot_matrix_display

// [logic/dot_matrix_controller.sv]
`timescale 1ns/100ps
// Behaviour
// [RULE_01] Four 5x7 characters share rows, columns
// [RULE_02] 28-bit serial-in parallel-out shift register
// [RULE_03] Data in at bit 1, out bit 28
// [RULE_04] One bit on, zero bit off
// [RULE_05] Shift on falling clock edge, seven bits/char
// [RULE_06] Send character 4 first, character 1 last
// [RULE_07] Strobe column only after 28 bits
// [RULE_08] Repeat load and strobe for five columns
// [RULE_09] Columns low while shifting data
// [RULE_10] Blanking low keeps all LEDs dark
// [RULE_11] One column at a time, switch when off
module dot_matrix_controller (
    input wire logic ref_clk, // Clock
    input wire logic reset_n, // Sync reset
    input wire logic frame_valid, // Column word offered
    output logic frame_ready, // FIFO can take word
    input wire logic [dot_matrix_pkg::SHIFT_BITS-1:0] frame_data, // Bit 27 sent first
    input wire logic display_enable, // Unblank display
    output logic [dot_matrix_pkg::COL_W-1:0] column_index, // Current column
    dot_matrix_link.controller link // Display side
);
    typedef enum logic [1:0] {IDLE, SHIFT_HIGH, SHIFT_LOW, STROBE} state_e;

    state_e state_q, state_d;
    logic [4:0] bit_q, bit_d;
    logic [dot_matrix_pkg::CNT_W-1:0] tmr_q, tmr_d;
    logic [dot_matrix_pkg::SHIFT_BITS-1:0] word_q, word_d;
    logic sclk_q, sclk_d;
    logic sdat_q, sdat_d;
    logic [dot_matrix_pkg::COL_W-1:0] col_q, col_d;
    logic [dot_matrix_pkg::COL_COUNT-1:0] strobe_q, strobe_d;
    logic blank_q, blank_d;
    logic [dot_matrix_pkg::SHIFT_BITS-1:0] head;
    logic pop_ok;
    logic pop;
    logic load;
    logic fall_now;
    logic next_bit;
    logic strobe_on;
    logic strobe_end;

    // ----------------------------------------
    // Column word buffer
    // ----------------------------------------
    column_fifo #(
        .WIDTH(dot_matrix_pkg::FIFO_WIDTH),
        .DEPTH(dot_matrix_pkg::FIFO_DEPTH)
    ) column_fifo_inst (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .in_valid(frame_valid),
        .in_ready(frame_ready),
        .in_data(frame_data),
        .out_valid(pop_ok),
        .out_ready(pop),
        .out_data(head)
    );

    // ----------------------------------------
    // Column wrap and timer compare
    // ----------------------------------------
    function automatic logic [dot_matrix_pkg::COL_W-1:0] next_col(input logic [dot_matrix_pkg::COL_W-1:0] c);
        next_col = (c == dot_matrix_pkg::COL_W'(dot_matrix_pkg::COL_COUNT - 1)) ?
            '0 : dot_matrix_pkg::COL_W'(c + 1'b1);
    endfunction

    function automatic logic timer_at(
        input logic [dot_matrix_pkg::CNT_W-1:0] t, // Running count
        input int unsigned limit // Last count of the phase
    );
        timer_at = (t == dot_matrix_pkg::CNT_W'(limit));
    endfunction

    // ----------------------------------------
    // Load and strobe sequencer
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        bit_d = bit_q;
        tmr_d = dot_matrix_pkg::CNT_W'(tmr_q + 1'b1);
        pop = 1'b0;
        load = 1'b0;
        fall_now = 1'b0;
        next_bit = 1'b0;
        strobe_on = 1'b0;
        strobe_end = 1'b0;
        case (state_q)
            IDLE: begin
                tmr_d = '0;
                if (pop_ok) begin
                    pop = 1'b1;
                    load = 1'b1;
                    bit_d = 5'h00;
                    state_d = SHIFT_HIGH;
                end
            end
            SHIFT_HIGH: begin
                if (timer_at(tmr_q, dot_matrix_pkg::CLK_HALF_CYC - 1)) begin
                    tmr_d = '0;
                    fall_now = 1'b1; // [RULE_05]
                    state_d = SHIFT_LOW;
                end
            end
            SHIFT_LOW: begin
                if (timer_at(tmr_q, dot_matrix_pkg::CLK_HALF_CYC - 1)) begin
                    tmr_d = '0;
                    if (bit_q == 5'(dot_matrix_pkg::SHIFT_BITS - 1)) begin
                        state_d = STROBE; // [RULE_07]
                    end else begin
                        bit_d = 5'(bit_q + 1'b1);
                        next_bit = 1'b1;
                        state_d = SHIFT_HIGH;
                    end
                end
            end
            STROBE: begin
                // Full strobe time: on for counts 0 to STROBE_CYC-1
                if (timer_at(tmr_q, dot_matrix_pkg::STROBE_CYC)) begin
                    tmr_d = '0;
                    strobe_end = 1'b1; // [RULE_08]
                    state_d = IDLE;
                end else begin
                    strobe_on = 1'b1; // [RULE_07]
                end
            end
            default: begin
                state_d = IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_q <= IDLE;
            bit_q <= 5'h00;
            tmr_q <= '0;
        end else begin
            state_q <= state_d;
            bit_q <= bit_d;
            tmr_q <= tmr_d;
        end
    end

    // ----------------------------------------
    // Serial data and shift clock
    // ----------------------------------------
    always_comb begin
        word_d = word_q;
        sdat_d = sdat_q;
        sclk_d = sclk_q;
        if (load) begin
            word_d = head;
            sdat_d = head[dot_matrix_pkg::SHIFT_BITS-1]; // [RULE_06]
            sclk_d = 1'b1;
        end else if (fall_now) begin
            sclk_d = 1'b0; // [RULE_05]
        end else if (next_bit) begin
            word_d = {word_q[dot_matrix_pkg::SHIFT_BITS-2:0], 1'b0};
            sdat_d = word_q[dot_matrix_pkg::SHIFT_BITS-2]; // [RULE_06]
            sclk_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            word_q <= dot_matrix_pkg::SHIFT_RESET;
            sdat_q <= 1'b0;
            sclk_q <= 1'b1;
        end else begin
            word_q <= word_d;
            sdat_q <= sdat_d;
            sclk_q <= sclk_d;
        end
    end

    // ----------------------------------------
    // Column strobe and blanking
    // ----------------------------------------
    always_comb begin
        col_d = col_q;
        strobe_d = dot_matrix_pkg::STROBE_OFF; // [RULE_09] [RULE_11]
        blank_d = display_enable; // [RULE_10]
        if (strobe_on) begin
            strobe_d = dot_matrix_pkg::COL_COUNT'(1) << col_q; // [RULE_07] [RULE_11]
        end
        if (strobe_end) begin
            col_d = next_col(col_q); // [RULE_08]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            col_q <= '0;
            strobe_q <= dot_matrix_pkg::STROBE_OFF;
            blank_q <= 1'b0;
        end else begin
            col_q <= col_d;
            strobe_q <= strobe_d;
            blank_q <= blank_d;
        end
    end

    // ----------------------------------------
    // Link and status outputs
    // ----------------------------------------
    assign link.shift_clock = sclk_q;
    assign link.serial_data_in = sdat_q;
    assign link.column_strobe_input = strobe_q;
    assign link.blanking_input = blank_q;
    assign column_index = col_q;
endmodule // dot_matrix_controller

// [bench/dot_matrix_assertions.sv]
`timescale 1ns/100ps
module dot_matrix_assertions (
    input wire logic ref_clk, // Clock
    input wire logic reset_n, // Sync reset
    input wire logic shift_clock, // Serial clock
    input wire logic serial_data_in, // Serial data
    input wire logic serial_data_out, // Cascade out
    input wire logic [4:0] column_strobe_input, // Strobes
    input wire logic blanking_input // Low blanks
);
    logic [12:0] on_q;
    logic [5:0] falls_q;
    logic [4:0] last_q;
    logic sc_q;
    wire lit = |column_strobe_input;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // Strobe length, falls per column, last column
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            on_q <= 13'h0000;
            falls_q <= 6'h00;
            last_q <= 5'h00;
            sc_q <= 1'b1;
        end else begin
            on_q <= lit ? on_q + 13'h0001 : 13'h0000;
            sc_q <= shift_clock;
            last_q <= lit ? column_strobe_input : last_q;
            if (lit) begin
                falls_q <= 6'h00;
            end else if (sc_q && !shift_clock) begin
                falls_q <= falls_q + 6'h01;
            end
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_strobe_one_hot: assert property ($onehot0(column_strobe_input))
        else $error("more than one column strobe");
    a_dark_while_shift: assert property (lit |-> $stable(shift_clock))
        else $error("shift clock moved while column lit");
    a_half_period_min: assert property ($changed(shift_clock) |=> $stable(shift_clock) [*8])
        else $error("shift clock half period too short");
    a_data_setup: assert property ($fell(shift_clock) |-> $stable(serial_data_in))
        else $error("serial data changed at falling clock");
    a_full_column_load: assert property ($rose(lit) |-> falls_q == 6'h1C)
        else $error("column strobed without 28 bits");
    a_fall_count_bound: assert property (falls_q <= 6'h1C)
        else $error("more than 28 shifts per column");
    a_strobe_length: assert property ($fell(lit) |-> on_q == 13'h0FA0)
        else $error("column strobe length wrong");
    a_column_order: assert property ($rose(lit) && last_q != 5'h00 |->
        column_strobe_input == {last_q[3:0], last_q[4]})
        else $error("columns out of order");
    a_reset_idle: assert property (disable iff (1'b0) !reset_n |=> shift_clock && !lit && !blanking_input)
        else $error("link not idle after reset");
    c_strobe: cover property ($rose(lit));
    c_blanked_strobe: cover property (lit && !blanking_input);
    c_last_column: cover property ($rose(column_strobe_input[4]));
endmodule // dot_matrix_assertions

// [bench/dot_matrix_column_shift_driver_tb.sv]
`timescale 1ns/100ps
module dot_matrix_column_shift_driver_tb;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic frame_valid = 1'b0;
    logic [27:0] frame_data = 28'h0000000;
    logic display_enable = 1'b1;
    logic frame_ready;
    logic [2:0] column_index;
    logic [27:0] row_drive;
    logic [4:0] column_lit;
    logic refused = 1'b0;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    dot_matrix_link link_if ();
    dot_matrix_controller dot_matrix_controller_inst (.ref_clk(ref_clk), .reset_n(reset_n),
        .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_data(frame_data),
        .display_enable(display_enable), .column_index(column_index), .link(link_if));
    dot_matrix_display dot_matrix_display_inst (.ref_clk(ref_clk), .reset_n(reset_n), .link(link_if),
        .row_drive(row_drive), .column_lit(column_lit));
    dot_matrix_assertions dot_matrix_assertions_inst (.ref_clk(ref_clk), .reset_n(reset_n),
        .shift_clock(link_if.shift_clock), .serial_data_in(link_if.serial_data_in),
        .serial_data_out(link_if.serial_data_out), .column_strobe_input(link_if.column_strobe_input),
        .blanking_input(link_if.blanking_input));
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    function automatic logic [27:0] pat(input int i);
        return (i == 0) ? 28'hFFFFFFF : 28'h9E3C5A1 ^ (28'h1111111 * i[27:0]);
    endfunction
    task automatic check(input logic [27:0] got, input logic [27:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ----------------------------------------
    // Word offer, held until taken
    // ----------------------------------------
    task automatic limit_hit();
        n_errors++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    endtask
    task automatic push(input logic [27:0] d);
        int k;
        k = 0;
        frame_valid = 1'b1;
        frame_data = d;
        while (frame_ready !== 1'b1 && k < 9000) begin
            refused = 1'b1;
            k++;
            @(negedge ref_clk);
        end
        if (k == 9000) begin
            limit_hit();
        end
        @(negedge ref_clk);
    endtask
    task automatic wait_strobe(input logic on);
        int k;
        k = 0;
        while ((|link_if.column_strobe_input) !== on && k < 9000) begin
            k++;
            @(negedge ref_clk);
        end
        if (k == 9000) begin
            limit_hit();
        end
    endtask
    task automatic finish_test();
        $display("errors=%0d tests=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 70000) begin
            n_errors++;
            finish_test();
        end
    end
    // ----------------------------------------
    // Ten columns queued; buffer fills, one blanked
    // ----------------------------------------
    initial begin
        logic [27:0] p;
        repeat (6) @(negedge ref_clk);
        reset_n = 1'b1;
        fork
            begin
                for (int i = 0; i < 10; i++) push(pat(i));
                frame_valid = 1'b0;
            end
            for (int i = 0; i < 10; i++) begin
                p = pat(i);
                display_enable = (i != 6);
                wait_strobe(1'b1);
                repeat (8) @(negedge ref_clk);
                check(row_drive, (i == 6) ? 28'h0000000 : p);
                check({23'h000000, column_lit}, (i == 6) ? 28'h0000000 : 28'h1 << (i % 5));
                check({27'h0000000, link_if.serial_data_out}, {27'h0000000, p[27]});
                check({25'h0000000, column_index}, 28'(i % 5));
                wait_strobe(1'b0);
            end
        join
        check({27'h0000000, refused}, 28'h0000001);
        finish_test();
    end
endmodule // dot_matrix_column_shift_driver_tb
